// file: pkg/bsr_pkg.sv
/*
 Shared constants of the battery-backed memory with calendar clock:
 address map, control byte layout, reset values and timing counts.
 Assumes a single 20 MHz system clock for all users of the package.
*/
package bsr_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 8192;
   // Clock bytes sit at the top eight locations
   localparam logic [12:0] CLOCK_BASE = 13'h1FF8;
   localparam logic [2:0] IDX_CONTROL = 3'h0;
   localparam logic [2:0] IDX_SECONDS = 3'h1;
   localparam logic [2:0] IDX_MINUTES = 3'h2;
   localparam logic [2:0] IDX_HOURS = 3'h3;
   localparam logic [2:0] IDX_DAY = 3'h4;
   localparam logic [2:0] IDX_DATE = 3'h5;
   localparam logic [2:0] IDX_MONTH = 3'h6;
   localparam logic [2:0] IDX_YEAR = 3'h7;
   // Control byte fields
   localparam int CTRL_HALT_BIT = 7;
   localparam int CTRL_SET_BIT = 6;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CLOCK_BYTE_RESET = 8'h00;
   // Counter first values and fixed limits, indexed like the clock bytes
   localparam logic [7:0] FIELD_MIN [1:7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
   localparam logic [7:0] FIELD_MAX [1:7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99};
   localparam logic [7:0] MONTH_FEB = 8'h02;
   localparam logic [7:0] MONTH_APR = 8'h04;
   localparam logic [7:0] MONTH_JUN = 8'h06;
   localparam logic [7:0] MONTH_SEP = 8'h09;
   localparam logic [7:0] MONTH_NOV = 8'h11;
   localparam logic [7:0] DAYS_28 = 8'h28;
   localparam logic [7:0] DAYS_29 = 8'h29;
   localparam logic [7:0] DAYS_30 = 8'h30;
   localparam logic [7:0] DAYS_31 = 8'h31;
   // Value shown while read data is not yet valid
   localparam logic [7:0] UNDEF_FILL = 8'hFF;
   // Timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int LOCATION_ACCESS_TIME_NS = 100;
   localparam int READ_HOLD_TIME_NS = 5;
   localparam int ONE_SECOND_NS = 1000000000;
   localparam int ACCESS_CYC_RAW = LOCATION_ACCESS_TIME_NS / CLK_PERIOD_NS;
   localparam int ACCESS_CYC = (ACCESS_CYC_RAW < 1) ? 1 : ACCESS_CYC_RAW;
   localparam int HOLD_CYC = (READ_HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SECOND_CYC = ONE_SECOND_NS / CLK_PERIOD_NS;
   localparam int AGE_W = 4;
endpackage : bsr_pkg

// file: hw/bsr_bcd_field.sv
/*
 One BCD calendar counter field with wrap to a first value and carry out.
 Assumes the limit and load value are valid BCD from the same clock domain.
*/
module bsr_bcd_field
   import bsr_pkg::*;
#(
   parameter logic [7:0] MIN_VAL = 8'h00
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic step,
   input wire logic load,
   input wire logic [7:0] load_value,
   input wire logic [7:0] limit,
   output logic [7:0] value,
   output logic carry
);
   logic [7:0] inc_value;
   logic [7:0] next_value;

   // BCD increment
   assign inc_value = (value[3:0] == 4'h9) ? {value[7:4] + 4'h1, 4'h0} :
                      {value[7:4], value[3:0] + 4'h1};
   assign carry = step && (value == limit);
   assign next_value = load ? load_value :
                       carry ? MIN_VAL :
                       step ? inc_value : value;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         value <= MIN_VAL;
      else
         value <= next_value;
   end
endmodule : bsr_bcd_field

// file: hw/bsr_top.sv
/*
 Battery-backed 8192-byte memory with a BCD calendar clock in its top
 eight locations, reached over an asynchronous parallel memory bus.
 Assumes all pins are asynchronous to ref_clk and are synchronised here;
 the supply comparators arrive as two level inputs.
*/
module bsr_top
   import bsr_pkg::*;
#(
   parameter int TICK_CYCLES = SECOND_CYC
)
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] location_lines,
   input wire logic [DATA_W-1:0] byte_lines_in,
   output logic [DATA_W-1:0] byte_lines_out,
   output logic byte_lines_oe,
   input wire logic select_low_active_n,
   input wire logic select_high_active,
   input wire logic out_enable_n,
   input wire logic write_strobe_n,
   input wire logic supply_in_tolerance,
   input wire logic supply_above_switch,
   output logic on_battery
);
   localparam int PIN_W = ADDR_W + DATA_W + 6;
   localparam int TICK_W = $clog2(TICK_CYCLES + 1);
   localparam logic [AGE_W-1:0] ACC_C = AGE_W'(ACCESS_CYC);
   localparam logic [AGE_W-1:0] HOLD_C = AGE_W'(HOLD_CYC);
   localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
   // Idle pin levels: deselected, writes blocked, supply out of tolerance but above the switch level
   localparam logic [PIN_W-1:0] PIN_IDLE = {{(ADDR_W + DATA_W){1'h0}}, 6'h2D};

   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] data_s;
   logic sel_low_n_s;
   logic sel_high_s;
   logic oe_n_s;
   logic we_n_s;
   logic sup_ok_s;
   logic sup_sw_s;
   logic [7:0] mem [0:MEM_DEPTH-1];
   logic [7:0] clk_byte [0:7];
   logic [ADDR_W-1:0] addr_q;
   logic [AGE_W-1:0] age;
   logic [TICK_W-1:0] tick_cnt;
   logic [7:0] cnt [1:7];
   logic [7:0] lim [1:7];
   logic [7:0] stp;
   logic [7:0] cry;
   logic copy_due;

   // Two-stage synchroniser for every pin
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         pin_meta <= PIN_IDLE;
         pin_sync <= PIN_IDLE;
      end
      else
      begin
         pin_meta <= {location_lines, byte_lines_in, select_low_active_n, select_high_active,
                      out_enable_n, write_strobe_n, supply_in_tolerance, supply_above_switch};
         pin_sync <= pin_meta;
      end
   end

   assign {addr_s, data_s, sel_low_n_s, sel_high_s, oe_n_s, we_n_s, sup_ok_s, sup_sw_s} = pin_sync;

   // Mode decode
   wire selected = !sel_low_n_s && sel_high_s && sup_ok_s;
   wire rd_mode = selected && we_n_s;
   wire wr_en = selected && !we_n_s;
   wire in_clock = (addr_s >= CLOCK_BASE);
   wire [2:0] clk_idx = addr_s[2:0];
   wire host_wr_clk = wr_en && in_clock;
   wire host_wr_mem = wr_en && !in_clock;
   wire host_wr_ctrl = host_wr_clk && (clk_idx == IDX_CONTROL);
   wire [7:0] ctrl = clk_byte[IDX_CONTROL];
   wire upd_halt = ctrl[CTRL_HALT_BIT] || ctrl[CTRL_SET_BIT];
   wire set_release = host_wr_ctrl && ctrl[CTRL_SET_BIT] && !data_s[CTRL_SET_BIT];
   wire tick = (tick_cnt == TICK_LAST);
   wire copy_now = copy_due && !upd_halt;
   wire [7:0] read_byte = in_clock ? clk_byte[clk_idx] : mem[addr_s];
   wire addr_changed = (addr_s != addr_q);
   wire data_valid = !addr_changed && (age >= ACC_C);
   wire hold_old = addr_changed || (age < HOLD_C);

   // Outputs drive only in read mode with output enable low
   assign byte_lines_oe = rd_mode && !oe_n_s;

   wire [7:0] next_out = data_valid ? read_byte :
                         hold_old ? byte_lines_out : UNDEF_FILL;

   // Leap year within a two-digit BCD year: divisible by four
   wire year_leap = cnt[7][4] ? (cnt[7][3:0] == 4'h2 || cnt[7][3:0] == 4'h6) :
                    (cnt[7][3:0] == 4'h0 || cnt[7][3:0] == 4'h4 || cnt[7][3:0] == 4'h8);
   wire month_30 = (cnt[6] == MONTH_APR) || (cnt[6] == MONTH_JUN) ||
                   (cnt[6] == MONTH_SEP) || (cnt[6] == MONTH_NOV);
   wire [7:0] date_lim = (cnt[6] == MONTH_FEB) ? (year_leap ? DAYS_29 : DAYS_28) :
                         month_30 ? DAYS_30 : DAYS_31;

   // Carry chain: seconds, minutes, hours, then day and date, month, year
   assign stp[0] = 1'b0;
   assign cry[0] = 1'b0;
   assign stp[1] = tick;
   assign stp[2] = cry[1];
   assign stp[3] = cry[2];
   assign stp[4] = cry[3];
   assign stp[5] = cry[3];
   assign stp[6] = cry[5];
   assign stp[7] = cry[6];

   genvar g;
   for (g = 1; g < 8; g++)
   begin : g_field
      assign lim[g] = (g == IDX_DATE) ? date_lim : FIELD_MAX[g];
      bsr_bcd_field #(.MIN_VAL(FIELD_MIN[g])) u_field
      (
         .ref_clk(ref_clk),
         .rst_n(rst_n),
         .step(stp[g]),
         .load(set_release),
         .load_value(clk_byte[g]),
         .limit(lim[g]),
         .value(cnt[g]),
         .carry(cry[g])
      );
   end

   // Seconds prescaler keeps running on battery
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || set_release || tick)
         tick_cnt <= '0;
      else
         tick_cnt <= tick_cnt + TICK_W'(1);
   end

   // Copy one cycle after the step so the bytes show the new time
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
         copy_due <= 1'b0;
      else
         copy_due <= tick;
   end

   // Clock bytes: host writes win over the once-a-second copy
   always_ff @(posedge ref_clk)
   begin
      for (int i = 0; i < 8; i++)
      begin
         if (!rst_n)
            clk_byte[i] <= (i == 0) ? CTRL_RESET : CLOCK_BYTE_RESET;
         else if (host_wr_clk && clk_idx == 3'(i))
            clk_byte[i] <= data_s;
         else if (copy_now && i != 0)
            clk_byte[i] <= cnt[i];
      end
   end

   // Memory array, never cleared so contents survive supply loss
   always_ff @(posedge ref_clk)
   begin
      if (host_wr_mem)
         mem[addr_s] <= data_s;
   end

   // Read path with access time and hold
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         addr_q <= '0;
         age <= '0;
         byte_lines_out <= UNDEF_FILL;
         on_battery <= 1'b0;
      end
      else
      begin
         addr_q <= addr_s;
         age <= addr_changed ? '0 : (age < ACC_C) ? age + AGE_W'(1) : age;
         byte_lines_out <= next_out;
         on_battery <= !sup_sw_s;
      end
   end

   a_deselect_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (sel_low_n_s || !sel_high_s) |-> !byte_lines_oe && !wr_en)
      else $error("deselected device drove or wrote");
   a_supply_blocks_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !sup_ok_s |-> !wr_en && !byte_lines_oe)
      else $error("write or drive with supply out of tolerance");
   a_read_drives_bus: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!sel_low_n_s && sel_high_s && sup_ok_s && we_n_s && !oe_n_s) |-> byte_lines_oe)
      else $error("read mode with output enable did not drive");
   a_oe_high_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      oe_n_s |-> !byte_lines_oe)
      else $error("lines driven with output enable high");
   a_change_holds_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
      addr_changed |=> $stable(byte_lines_out))
      else $error("old byte not held after address change");
   a_early_undefined: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!addr_changed && age == HOLD_C && HOLD_C < ACC_C) |=> byte_lines_out == UNDEF_FILL)
      else $error("data shown before access time");
   a_valid_read_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!addr_changed && age >= ACC_C && !wr_en) |=> byte_lines_out == $past(read_byte))
      else $error("wrong byte after access time");
   a_ctrl_write_back: assert property (@(posedge ref_clk) disable iff (!rst_n)
      host_wr_ctrl |=> clk_byte[IDX_CONTROL] == $past(data_s))
      else $error("control byte write lost");
   a_second_copy: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (copy_now && !host_wr_clk) |=> clk_byte[IDX_SECONDS] == $past(cnt[1]))
      else $error("seconds not copied on tick");
   a_hour_wraps: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (stp[3] && cnt[3] == 8'h23 && !set_release) |=> cnt[3] == 8'h00)
      else $error("hours did not wrap at 23");
   a_month_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (stp[5] && cnt[5] == date_lim && !set_release) |=> cnt[5] == 8'h01)
      else $error("date did not wrap at month end");
   a_mem_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
      host_wr_mem |=> mem[$past(addr_s)] == $past(data_s))
      else $error("memory write lost");
endmodule : bsr_top

// file: verif/bsr_host.sv
/*
 Host model: one bus read or write per request on the parallel memory pins.
 Assumes the device samples all pins on ref_clk through its synchronisers.
*/
module bsr_host
   import bsr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic cmd_go,
   input wire logic cmd_wr,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [DATA_W-1:0] cmd_data,
   input wire logic [DATA_W-1:0] dev_out,
   input wire logic dev_oe,
   output logic [ADDR_W-1:0] location_lines,
   output logic [DATA_W-1:0] wire_level,
   output logic select_low_active_n,
   output logic select_high_active,
   output logic out_enable_n,
   output logic write_strobe_n,
   output logic [DATA_W-1:0] rdata,
   output logic rdata_oe,
   output logic cmd_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drv;
   logic [DATA_W-1:0] hdata;
   logic [DATA_W-1:0] last;
   // Released lines float, so show a changing pattern
   assign wire_level = dev_oe ? dev_out : (drv ? hdata : ~last);
   always @(posedge ref_clk) last <= wire_level;
   initial
   begin
      {drv, hdata, last, location_lines, rdata, rdata_oe, cmd_done} = '0;
      {select_low_active_n, out_enable_n, write_strobe_n} = 3'b111;
      select_high_active = 1'b0;
   end
   always
   begin
      @(posedge ref_clk iff cmd_go);
      location_lines <= cmd_addr;
      select_low_active_n <= 1'b0;
      select_high_active <= 1'b1;
      drv <= cmd_wr;
      hdata <= cmd_data;
      write_strobe_n <= ~cmd_wr;
      out_enable_n <= cmd_wr;
      repeat (8) @(posedge ref_clk);
      rdata <= dev_out;
      rdata_oe <= dev_oe;
      write_strobe_n <= 1'b1;
      out_enable_n <= 1'b1;
      // Address and data held past strobe end
      repeat (3) @(posedge ref_clk);
      drv <= 1'b0;
      select_low_active_n <= 1'b1;
      select_high_active <= 1'b0;
      cmd_done <= 1'b1;
      @(posedge ref_clk);
      cmd_done <= 1'b0;
   end
endmodule : bsr_host

// file: verif/test_battery_backed_sram_with_rtc.sv
/*
 Self-checking bench: memory, clock bytes, calendar and supply scenarios.
 Assumes bsr_top with a short second and the host model on its bus.
*/
module test_battery_backed_sram_with_rtc;
   timeunit 1ns;
   timeprecision 1ns;
   import bsr_pkg::*;
   localparam int TICK = 200;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic go = 1'b0;
   logic wr = 1'b0;
   logic [12:0] addr = '0;
   logic [7:0] wdata = '0;
   logic sup_ok = 1'b1;
   logic sup_sw = 1'b1;
   logic [12:0] loc;
   logic [7:0] wl, rdata, dout;
   logic sel_n, sel_h, oe_n, we_n, rdata_oe, done, doe, on_batt;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   always #25 ref_clk = ~ref_clk;
   bsr_host i_bsr_host (.ref_clk(ref_clk), .cmd_go(go), .cmd_wr(wr), .cmd_addr(addr),
      .cmd_data(wdata), .dev_out(dout), .dev_oe(doe), .location_lines(loc),
      .wire_level(wl), .select_low_active_n(sel_n), .select_high_active(sel_h),
      .out_enable_n(oe_n), .write_strobe_n(we_n), .rdata(rdata), .rdata_oe(rdata_oe),
      .cmd_done(done));
   bsr_top #(.TICK_CYCLES(TICK)) i_bsr_top (.ref_clk(ref_clk), .rst_n(rst_n),
      .location_lines(loc), .byte_lines_in(wl), .byte_lines_out(dout),
      .byte_lines_oe(doe), .select_low_active_n(sel_n), .select_high_active(sel_h),
      .out_enable_n(oe_n), .write_strobe_n(we_n), .supply_in_tolerance(sup_ok),
      .supply_above_switch(sup_sw), .on_battery(on_batt));
   task close_out();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         err_total++;
         close_out();
      end
   end
   task check(logic [7:0] seen, logic [7:0] exp, string msg);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check
   task bus(logic w, logic [12:0] a, logic [7:0] d);
      int n;
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= d;
      for (n = 0; n < 100 && done !== 1'b1; n++) @(posedge ref_clk);
      check({7'h00, done}, 8'h01, "bus handshake");
      go <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task rd(logic [12:0] a, logic [7:0] exp, string msg);
      bus(1'b0, a, 8'h00);
      check(rdata, exp, msg);
      check({7'h00, rdata_oe}, 8'h01, "read drive");
   endtask : rd
   task t_mem();
      check({7'h00, doe}, 8'h00, "idle drive");
      bus(1'b1, 13'h0000, 8'hA5);
      check({7'h00, rdata_oe}, 8'h00, "drive in write");
      bus(1'b1, 13'h1FF7, 8'h3C);
      bus(1'b1, 13'h0001, 8'h5A);
      rd(13'h0000, 8'hA5, "byte 0000");
      rd(13'h1FF7, 8'h3C, "byte 1FF7");
      rd(13'h0001, 8'h5A, "byte 0001");
      bus(1'b1, CLOCK_BASE, 8'h15);
      rd(CLOCK_BASE, 8'h15, "control byte");
      $display("test memory done");
   endtask : t_mem
   task t_cal(logic [7:0] yr, logic [7:0] dt, logic [7:0] mo);
      logic [7:0] setv [1:7];
      logic [7:0] expv [1:7];
      setv = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, yr};
      expv = '{8'h00, 8'h00, 8'h00, 8'h01, dt, mo, yr};
      bus(1'b1, CLOCK_BASE, 8'h40);
      for (int i = 1; i <= 7; i++) bus(1'b1, CLOCK_BASE + 13'(i), setv[i]);
      bus(1'b1, CLOCK_BASE, 8'h00);
      repeat (TICK + TICK / 4) @(posedge ref_clk);
      for (int i = 1; i <= 7; i++) rd(CLOCK_BASE + 13'(i), expv[i], "clock byte");
      $display("test calendar done");
   endtask : t_cal
   task t_supply();
      sup_ok <= 1'b0;
      bus(1'b1, 13'h0001, 8'hC3);
      bus(1'b0, 13'h0001, 8'h00);
      check({7'h00, rdata_oe}, 8'h00, "drive while low supply");
      sup_sw <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check({7'h00, on_batt}, 8'h01, "battery flag");
      sup_sw <= 1'b1;
      sup_ok <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check({7'h00, on_batt}, 8'h00, "battery flag");
      rd(13'h0001, 8'h5A, "protected byte");
      $display("test supply done");
   endtask : t_supply
   initial
   begin
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      t_mem();
      t_cal(8'h04, 8'h29, 8'h02);
      t_cal(8'h03, 8'h01, 8'h03);
      t_supply();
      close_out();
   end
endmodule : test_battery_backed_sram_with_rtc
